// ==== rtl/stage_ctrl.sv ====
`timescale 1ns/100ps
`include "stage_ctrl_map.svh"
module stage_ctrl (
  // Clock, reset and frame tick
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     frame_tick,
  // Transition controls
  input  wire logic [`POS_W-1:0]        lever_pos,
  input  wire logic                     timed_transition_button,
  input  wire logic                     cut_button,
  input  wire logic [`DUR_W-1:0]        duration,
  input  wire logic                     recall_strobe,
  input  wire logic [`POS_W-1:0]        recall_pos,
  // Transition outputs
  output logic      [`POS_W-1:0]        trans_pos,
  output logic                          trans_done,
  output logic                          swap_sources,
  output logic                          lamp_up,
  output logic                          lamp_down,
  output logic                          lever_active,
  output logic                          timed_lamp,
  // Keyer controls
  input  wire logic                     layered_mode,
  input  wire logic [1:0]               delegate_sel,
  input  wire logic [3:0]               keyer_on_air,
  input  wire logic                     mode_press,
  input  wire stage_ctrl_pkg::key_mode_t mode_sel,
  input  wire logic                     auto_sel_source,
  input  wire logic                     knob_we,
  input  wire logic [`CG_W-1:0]         clip_knob,
  input  wire logic [`CG_W-1:0]         gain_knob,
  input  wire logic                     video_fill_press,
  input  wire logic                     matte_fill_press,
  input  wire logic                     split_set,
  // Keyer outputs
  output logic      [1:0]               delegate_q,
  output logic                          key_in_use_lamp,
  output stage_ctrl_pkg::key_mode_t     key_mode_q,
  output logic                          linear_lamp,
  output logic                          lum_lamp,
  output logic                          s_shape_en,
  output logic                          wipe_key_src,
  output logic      [`CG_W-1:0]         clip_q,
  output logic      [`CG_W-1:0]         gain_q,
  output logic                          video_fill_q,
  output logic                          matte_fill,
  output logic                          split_lamp
);
  import stage_ctrl_pkg::*;

  tr_state_t         st_q;
  logic [`POS_W-1:0] step;
  logic [`POS_W-1:0] start_q;
  logic              dir_q;      // 1: moving toward full
  logic              lever_lock_q, mirror_q;
  logic              btn_q, cut_q;
  logic              btn_p, cut_p;
  logic              lev_at_lo, lev_at_hi, at_end;
  logic [`POS_W-1:0] target, remain, lev_eff;
  logic [`POS_W:0]   diff;
  logic              caught;

  step_calc u_step (
    .clk_sys (clk_sys),
    .rst     (rst),
    .dur     (duration),
    .step    (step)
  );

  // Button edge detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      btn_q <= 1'b0;
      cut_q <= 1'b0;
    end else begin
      btn_q <= timed_transition_button;
      cut_q <= cut_button;
    end
  end
  assign btn_p = timed_transition_button & ~btn_q;
  assign cut_p = cut_button & ~cut_q;

  assign lev_at_lo = (lever_pos == '0);
  assign lev_at_hi = (lever_pos == `POS_FULL);
  assign at_end    = (trans_pos == '0) || (trans_pos == `POS_FULL);
  assign target    = dir_q ? `POS_FULL : '0;
  assign remain    = dir_q ? (`POS_FULL - trans_pos) : trans_pos;
  assign lev_eff   = mirror_q ? (`POS_FULL - lever_pos) : lever_pos;
  assign diff      = {1'b0, lev_eff} - {1'b0, trans_pos};
  // Lever has caught the transition point
  assign caught = (diff[`POS_W] ? (trans_pos - lev_eff)
                                : diff[`POS_W-1:0]) <= `NEAR_TOL;

  // Transition engine
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q         <= ST_IDLE;
      trans_pos    <= '0;
      start_q      <= '0;
      dir_q        <= 1'b1;
      lever_lock_q <= 1'b0;
      mirror_q     <= 1'b0;
      trans_done   <= 1'b0;
      swap_sources <= 1'b0;
    end else begin
      trans_done   <= 1'b0;
      swap_sources <= 1'b0;
      if (recall_strobe) begin
        trans_pos    <= recall_pos;
        lever_lock_q <= (recall_pos != lev_eff);
        st_q         <= (recall_pos == '0 || recall_pos == `POS_FULL) ?
                        ST_IDLE : ST_LEVER;
        dir_q        <= (recall_pos == `POS_FULL) ? 1'b0 :
                        (recall_pos == '0) ? 1'b1 : dir_q;
      end else if (cut_p && st_q != ST_IDLE) begin
        swap_sources <= 1'b1;
      end else if (cut_p) begin
        trans_done   <= 1'b1;
        trans_pos    <= target;
        dir_q        <= ~dir_q;
        if (!lever_lock_q) mirror_q <= ~mirror_q;
      end else begin
        unique case (st_q)
          ST_IDLE: begin
            if (btn_p) begin
              if (duration == '0) begin
                trans_done <= 1'b1;
                trans_pos  <= target;
                dir_q      <= ~dir_q;
                if (!lever_lock_q) mirror_q <= ~mirror_q;
              end else begin
                st_q    <= ST_TIMED;
                start_q <= trans_pos;
              end
            end else if (lever_lock_q) begin
              if (lev_at_lo || lev_at_hi) begin
                lever_lock_q <= 1'b0;
                mirror_q     <= mirror_q ^ (lev_eff != trans_pos); // No jump
              end
            end else if (lev_eff != trans_pos) begin
              st_q      <= ST_LEVER;
              start_q   <= trans_pos;
              trans_pos <= lev_eff;
            end
          end
          ST_LEVER: begin
            if (btn_p) begin
              st_q <= ST_TIMED;
              if (!lever_lock_q) lever_lock_q <= 1'b1;
            end else if (lever_lock_q) begin
              if (caught) lever_lock_q <= 1'b0;
            end else begin
              trans_pos <= lev_eff;
              if (lev_eff == target) begin
                st_q       <= ST_IDLE;
                trans_done <= 1'b1;
                dir_q      <= ~dir_q;
              end else if (lev_eff == start_q && at_end) begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_TIMED: begin
            if (btn_p) begin
              st_q <= ST_FROZEN;
            end else if (frame_tick) begin
              if (remain <= step) begin
                trans_pos  <= target;
                st_q       <= ST_IDLE;
                trans_done <= 1'b1;
                dir_q      <= ~dir_q;
                lever_lock_q <= ~(lev_eff == target);
              end else begin
                trans_pos <= dir_q ? trans_pos + step
                                   : trans_pos - step;
                lever_lock_q <= 1'b1;
              end
            end
          end
          ST_FROZEN: begin
            if (btn_p) begin
              st_q <= ST_TIMED;
            end else if (lev_eff == target) begin
              trans_pos  <= target;
              st_q       <= ST_IDLE;
              trans_done <= 1'b1;
              dir_q      <= ~dir_q;
              lever_lock_q <= 1'b0;
            end else if (caught) begin
              lever_lock_q <= 1'b0;
              st_q         <= ST_LEVER;
            end
          end
        endcase
      end
    end
  end

  // Lamps
  assign lever_active = ~lever_lock_q;
  assign timed_lamp   = (st_q == ST_TIMED);
  always_comb begin
    if (lever_lock_q && st_q == ST_IDLE) begin
      lamp_up   = 1'b1;
      lamp_down = 1'b1;
    end else begin
      lamp_up   = dir_q;
      lamp_down = ~dir_q;
    end
  end

  // Keyer delegation
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      delegate_q <= 2'd0;
    end else if (!layered_mode && delegate_q[1]) begin
      delegate_q <= 2'd0;
    end else if (layered_mode || !delegate_sel[1]) begin
      delegate_q <= delegate_sel;
    end
  end
  assign key_in_use_lamp = keyer_on_air[delegate_q];

  // Clip and gain memory: path x mode (lum, chroma, linear)
  logic [`CG_W-1:0] clip_mem [6];
  logic [`CG_W-1:0] gain_mem [6];
  logic [2:0]       slot;
  logic             pattern;
  logic             force_unity;
  assign pattern = (key_mode_q == KM_PRI_PAT) || (key_mode_q == KM_SEC_PAT);
  assign slot = {2'b00, auto_sel_source} * 3'd3 +
                ((key_mode_q == KM_CHROMA) ? 3'd1 :
                 (key_mode_q == KM_LINEAR) ? 3'd2 : 3'd0);
  assign force_unity = mode_press && mode_sel == KM_LINEAR;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_cg
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          clip_mem[gi] <= `CG_UNITY;
          gain_mem[gi] <= `CG_UNITY;
        end else if (force_unity && gi == 2 + 3 * auto_sel_source) begin
          clip_mem[gi] <= `CLIP_HALF;
          gain_mem[gi] <= `CG_UNITY;
        end else if (knob_we && !pattern && !force_unity &&
                     !mode_press && gi == slot) begin
          clip_mem[gi] <= clip_knob;
          gain_mem[gi] <= gain_knob;
        end
      end
    end
  endgenerate

  // Key mode, fill and split state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      key_mode_q   <= KM_LUM;
      video_fill_q <= 1'b1;
      split_lamp   <= 1'b0;
      clip_q       <= `CG_UNITY;
      gain_q       <= `CG_UNITY;
    end else begin
      if (mode_press && !(mode_sel == KM_CHROMA && delegate_q[1]))
        key_mode_q <= mode_sel;
      if (mode_press && (mode_sel == KM_PRI_PAT || mode_sel == KM_SEC_PAT))
        split_lamp <= 1'b0;
      else if (split_set && !pattern)
        split_lamp <= 1'b1;
      if (layered_mode && delegate_sel[1])
        video_fill_q <= 1'b1;
      else if (video_fill_press)
        video_fill_q <= 1'b1;
      else if (matte_fill_press && !delegate_q[1])
        video_fill_q <= 1'b0;
      clip_q <= clip_mem[slot];
      gain_q <= gain_mem[slot];
    end
  end

  assign matte_fill   = ~video_fill_q;
  assign wipe_key_src = pattern;
  assign s_shape_en   = (key_mode_q == KM_LUM);
  assign linear_lamp  = (key_mode_q == KM_LINEAR);
  assign lum_lamp     = (key_mode_q == KM_LUM) ||
                        (linear_lamp && (clip_q != `CLIP_HALF ||
                                         gain_q != `CG_UNITY));

  // Checks
  property p_cut_idle;
    @(posedge clk_sys) disable iff (rst)
      (cut_p && st_q == ST_IDLE && !recall_strobe) |=> trans_done;
  endproperty
  a_cut_idle: assert property (p_cut_idle) else $error("idle cut lost");
  property p_cut_busy;
    @(posedge clk_sys) disable iff (rst)
      (cut_p && st_q != ST_IDLE && !recall_strobe)
        |=> swap_sources && $stable(trans_pos);
  endproperty
  a_cut_busy: assert property (p_cut_busy) else $error("busy cut moved");
  sequence s_freeze_req;
    st_q == ST_TIMED && btn_p && !cut_p && !recall_strobe;
  endsequence
  property p_freeze;
    @(posedge clk_sys) disable iff (rst)
      s_freeze_req |=> st_q == ST_FROZEN;
  endproperty
  a_freeze: assert property (p_freeze) else $error("no freeze");
  property p_lamps;
    @(posedge clk_sys) disable iff (rst)
      (st_q == ST_TIMED && frame_tick && remain <= step && lev_eff != target
       && !btn_p && !cut_p && !recall_strobe) |=> lamp_up && lamp_down;
  endproperty
  a_lamps: assert property (p_lamps) else $error("lamps wrong");
  property p_deleg;
    @(posedge clk_sys) disable iff (rst)
      !layered_mode |=> !delegate_q[1];
  endproperty
  a_deleg: assert property (p_deleg) else $error("bad delegation");
  property p_fill;
    @(posedge clk_sys) disable iff (rst)
      (layered_mode && delegate_sel[1]) |=> video_fill_q;
  endproperty
  a_fill: assert property (p_fill) else $error("fill not forced");
  property p_split;
    @(posedge clk_sys) disable iff (rst)
      (mode_press && mode_sel == KM_PRI_PAT) |=> !split_lamp;
  endproperty
  a_split: assert property (p_split) else $error("split lamp on");
  property p_zero;
    @(posedge clk_sys) disable iff (rst)
      (st_q == ST_IDLE && btn_p && duration == '0 && !cut_p &&
       !recall_strobe) |=> trans_done && st_q == ST_IDLE;
  endproperty
  a_zero: assert property (p_zero) else $error("zero not cut");
endmodule

// ==== rtl/stage_ctrl_map.svh ====
`ifndef STAGE_CTRL_MAP_SVH
`define STAGE_CTRL_MAP_SVH
`define POS_W       16
`define POS_FULL    16'hFFFF
`define DUR_W       10
`define DUR_MAX     10'h03E7
`define CG_W        8
`define CG_UNITY    8'h80
`define CLIP_HALF   8'h80
`define NEAR_TOL    16'h0100
`endif

// ==== rtl/stage_ctrl_pkg.sv ====
package stage_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LEVER  = 2'b01,
    ST_TIMED  = 2'b10,
    ST_FROZEN = 2'b11
  } tr_state_t;
  typedef enum logic [2:0] {
    KM_LUM = 3'b000, KM_CHROMA = 3'b001, KM_LINEAR = 3'b010,
    KM_PRI_PAT = 3'b011, KM_SEC_PAT = 3'b100
  } key_mode_t;
endpackage

// ==== rtl/step_calc.sv ====
`timescale 1ns/100ps
`include "stage_ctrl_map.svh"
// Per-frame step = full scale / duration (sequential divider)
module step_calc (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic [`DUR_W-1:0]  dur,
  output logic      [`POS_W-1:0]  step
);
  logic [`DUR_W-1:0] dur_q;
  logic [4:0]        cnt_q;
  logic [`POS_W-1:0] quo_q;
  logic [`DUR_W:0]   rem_q;
  logic [`DUR_W:0]   trial;
  assign trial = {rem_q[`DUR_W-1:0], 1'b1} ;
  // Restoring division of 0xFFFF by dur, restarted on change
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dur_q <= '0;
      cnt_q <= '0;
      quo_q <= '0;
      rem_q <= '0;
      step  <= `POS_FULL;
    end else if (dur != dur_q || cnt_q == 5'd0) begin
      dur_q <= dur;
      cnt_q <= 5'd16;
      quo_q <= '0;
      rem_q <= '0;
    end else if (cnt_q == 5'd1) begin
      cnt_q <= 5'd0;
      step  <= (dur_q == '0) ? `POS_FULL :
               (trial >= {1'b0, dur_q} ? {quo_q[`POS_W-2:0], 1'b1}
                                        : {quo_q[`POS_W-2:0], 1'b0});
    end else begin
      cnt_q <= cnt_q - 5'd1;
      if (trial >= {1'b0, dur_q}) begin
        rem_q <= trial - {1'b0, dur_q};
        quo_q <= {quo_q[`POS_W-2:0], 1'b1};
      end else begin
        rem_q <= trial;
        quo_q <= {quo_q[`POS_W-2:0], 1'b0};
      end
    end
  end
endmodule

// ==== test/front_panel.sv ====
`timescale 1ns/100ps
// Operator lever model: travels toward the goal at the requested rate
module front_panel (
  // Clock
  input  wire logic        clk_sys,
  // Operator intent
  input  wire logic [15:0] lever_goal,
  input  wire logic [15:0] lever_rate,
  // Lever position
  output logic      [15:0] lever_pos
);
  logic [15:0] gap;

  initial lever_pos = 16'h0000;

  // Remaining travel to the goal
  assign gap = (lever_goal > lever_pos) ? lever_goal - lever_pos
                                        : lever_pos - lever_goal;

  // Move on the falling edge, never overshooting the goal
  always @(negedge clk_sys) begin
    if (gap <= lever_rate)
      lever_pos <= lever_goal;
    else if (lever_goal > lever_pos)
      lever_pos <= lever_pos + lever_rate;
    else
      lever_pos <= lever_pos - lever_rate;
  end
endmodule

// ==== test/stage_ctrl_test.sv ====
`timescale 1ns/100ps
`include "stage_ctrl_map.svh"
module stage_ctrl_test;
  import stage_ctrl_pkg::*;
  // Single-bit controls and indicators
  logic clk_sys, rst, frame_tick, timed_transition_button, cut_button;
  logic recall_strobe, layered_mode, mode_press, auto_sel_source, knob_we;
  logic video_fill_press, matte_fill_press, split_set, trans_done;
  logic swap_sources, lamp_up, lamp_down, lever_active, timed_lamp;
  logic key_in_use_lamp, linear_lamp, lum_lamp, s_shape_en, wipe_key_src;
  logic video_fill_q, matte_fill, split_lamp;
  // Buses
  logic      [15:0] lever_pos, recall_pos, trans_pos, lever_goal, lever_rate;
  logic      [15:0] p;
  logic      [9:0]  duration;
  logic      [1:0]  delegate_sel, delegate_q;
  logic      [3:0]  keyer_on_air;
  logic      [7:0]  clip_knob, gain_knob, clip_q, gain_q;
  logic      [31:0] seed, r;
  key_mode_t        mode_sel, key_mode_q;
  int               failures, n_compared, cycles, n_done, n_swap, k, e;

  front_panel panel (.clk_sys, .lever_goal, .lever_rate, .lever_pos);

  stage_ctrl dut (.clk_sys, .rst, .frame_tick, .lever_pos,
    .timed_transition_button, .cut_button, .duration, .recall_strobe,
    .recall_pos, .trans_pos, .trans_done, .swap_sources, .lamp_up,
    .lamp_down, .lever_active, .timed_lamp, .layered_mode, .delegate_sel,
    .keyer_on_air, .mode_press, .mode_sel, .auto_sel_source, .knob_we,
    .clip_knob, .gain_knob, .video_fill_press, .matte_fill_press,
    .split_set, .delegate_q, .key_in_use_lamp, .key_mode_q, .linear_lamp,
    .lum_lamp, .s_shape_en, .wipe_key_src, .clip_q, .gain_q,
    .video_fill_q, .matte_fill, .split_lamp);

  // Clock generation
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Count completions and swaps; cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (trans_done === 1'b1) n_done++;
    if (swap_sources === 1'b1) n_swap++;
    if (cycles == 30000) begin
      failures++;
      results();
    end
  end

  // Xorshift source of repeatable values
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic press(ref logic b);
    @(negedge clk_sys) b = 1'b1;
    @(negedge clk_sys) b = 1'b0;
  endtask

  task automatic frames(input int n);
    repeat (n) begin
      press(frame_tick);
      tick(2);
    end
  endtask

  // Move the lever at a random pace and let the stage settle
  task automatic lever(input logic [15:0] g);
    r = rnd();
    lever_rate = 16'h0100 + {5'h00, r[10:0]};
    lever_goal = g;
    for (int i = 0; i < 600 && lever_pos !== g; i++) tick(1);
    tick(3);
  endtask

  task automatic recall(input logic [15:0] v);
    recall_pos = v;
    press(recall_strobe);
    tick(2);
  endtask

  task automatic mode(input key_mode_t m);
    mode_sel = m;
    press(mode_press);
    tick(1);
  endtask

  task automatic knob(input logic [7:0] c, input logic [7:0] g);
    clip_knob = c;
    gain_knob = g;
    press(knob_we);
    tick(1);
  endtask

  task automatic results();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst, frame_tick, timed_transition_button, cut_button} = 4'hF;
    {recall_strobe, layered_mode, mode_press, auto_sel_source} = 4'h0;
    {knob_we, video_fill_press, matte_fill_press, split_set} = 4'h0;
    {frame_tick, timed_transition_button, cut_button} = 3'h0;
    {recall_pos, lever_goal, lever_rate} = 48'h0;
    {duration, delegate_sel, keyer_on_air} = 16'h0000;
    {clip_knob, gain_knob} = 16'h8080;
    mode_sel = KM_LUM;
    seed = 32'h0000_38f8;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    tick(20);
    check(trans_pos, 0);
    check({lamp_up, lamp_down, lever_active}, 3'b101);
    check({video_fill_q, matte_fill, clip_q, gain_q}, 18'h2_8080);
    // Lever follows, reverses, completes from both ends
    r = rnd();
    p = 16'h1000 + {2'b00, r[13:0]};
    lever(p);
    check(trans_pos, p);
    check({lamp_up, lamp_down}, 2'b10);
    lever(16'h0000);
    check({trans_pos, 8'(n_done)}, 0);
    lever(`POS_FULL);
    check({trans_pos, 8'(n_done)}, {`POS_FULL, 8'h01});
    check({lamp_up, lamp_down}, 2'b01);
    lever(16'h0000);
    check({trans_pos, 8'(n_done)}, 24'h0000_02);
    // Cut during lever transition, then timed finish
    lever(16'h4000);
    press(cut_button);
    tick(2);
    check({trans_pos, 8'(n_done), 8'(n_swap)}, 32'h4000_0201);
    duration = 10'd8;
    tick(20);
    press(timed_transition_button);
    tick(1);
    check(timed_lamp, 1);
    for (k = 0; k < 20 && n_done < 3; k++) frames(1);
    check(k >= 6 && k <= 7, 1);
    check({timed_lamp, lamp_up, lamp_down, lever_active}, 4'b0110);
    lever(16'h2000);
    check({trans_pos, lever_active}, {`POS_FULL, 1'b0});
    lever(16'h0000);
    check({trans_pos, lever_active}, {`POS_FULL, 1'b1});
    check(n_done, 3);
    // Recall away from the lever, then catch up
    recall(16'h8000);
    check(lever_active, 0);
    lever(16'h2000);
    check({trans_pos, lever_active}, 17'h1_0000);
    lever(16'h8000);
    check(lever_active, 1);
    recall(16'h0000);
    check({lamp_up, lamp_down, lever_active}, 3'b110);
    lever(16'h0000);
    check({lamp_up & lamp_down, lever_active}, 2'b01);
    // Timed run with lever locked: freeze, cut, resume
    recall(16'h8000);
    press(timed_transition_button);
    tick(1);
    check(timed_lamp, 1);
    frames(1);
    press(timed_transition_button);
    p = trans_pos;
    frames(2);
    check(trans_pos, p);
    press(cut_button);
    tick(2);
    check({trans_pos, 8'(n_swap)}, {p, 8'h02});
    press(timed_transition_button);
    for (k = 0; k < 12 && n_done < 4; k++) frames(1);
    check(n_done, 4);
    // Zero duration acts as a cut; idle cut is immediate
    duration = 10'd0;
    tick(20);
    press(timed_transition_button);
    tick(2);
    check({timed_lamp, 8'(n_done)}, 9'h005);
    p = trans_pos;
    press(cut_button);
    tick(1);
    check({trans_pos, 8'(n_done)}, {~p, 8'h06});
    // Linear progression at a random duration
    r = rnd();
    duration = 10'(20 + r % 900);
    tick(20);
    p = trans_pos;
    press(timed_transition_button);
    frames(5);
    e = 5 * (32'hFFFF / duration);
    k = (trans_pos > p) ? trans_pos - p : p - trans_pos;
    check(k >= e - 5 && k <= e + 5, 1);
    press(timed_transition_button);
    // Delegation, in-use lamp and fill forcing
    e = 0;
    for (int i = 0; i < 8; i++) begin
      layered_mode = i[2];
      delegate_sel = i[1:0];
      r = rnd();
      keyer_on_air = r[3:0];
      if (i[2] || i < 2) e = i % 4;
      press(matte_fill_press);
      tick(2);
      check(delegate_q, e);
      check(key_in_use_lamp, keyer_on_air[e]);
      check({video_fill_q, matte_fill}, (e >= 2) ? 2 : 1);
    end
    mode(KM_CHROMA);
    check(key_mode_q, KM_LUM);
    layered_mode = 1'b0;
    delegate_sel = 2'd0;
    tick(2);
    // Linear key unity handling
    mode(KM_LINEAR);
    check({clip_q, gain_q}, 16'h8080);
    check({linear_lamp, lum_lamp, s_shape_en}, 3'b100);
    knob(8'h90, 8'h80);
    check({linear_lamp, lum_lamp}, 2'b11);
    knob(8'h80, 8'h80);
    check(lum_lamp, 0);
    knob(8'h80, 8'h7F);
    check(lum_lamp, 1);
    mode(KM_LINEAR);
    check({clip_q, gain_q, lum_lamp}, 17'h1_0100);
    // Stored clip and gain per path and mode
    mode(KM_LUM);
    r = rnd();
    knob(r[7:0], r[15:8]);
    auto_sel_source = 1'b1;
    tick(2);
    knob(r[23:16], r[31:24]);
    mode(KM_CHROMA);
    knob(~r[7:0], ~r[15:8]);
    auto_sel_source = 1'b0;
    mode(KM_LUM);
    tick(1);
    check({clip_q, gain_q}, {r[7:0], r[15:8]});
    // Pattern keys take the wipe source and ignore knobs
    for (int i = 0; i < 2; i++) begin
      mode(KM_LUM);
      press(split_set);
      check(split_lamp, 1);
      mode(i ? KM_SEC_PAT : KM_PRI_PAT);
      p = {clip_q, gain_q};
      knob(~p[15:8], ~p[7:0]);
      check({wipe_key_src, split_lamp}, 2'b10);
      check({clip_q, gain_q}, p);
    end
    results();
  end
endmodule
